// ### verilog/sac_pkg.sv
package sac_pkg;

    localparam int PADDR_W  = 8;
    localparam int DATA_W   = 32;
    localparam int SYS_A_W  = 28;
    localparam int MODE_W   = 3;
    localparam int RFSH_W   = 12;
    localparam int ROW_W    = 14;
    localparam int COL_W    = 12;
    localparam int BANK_W   = 3;
    localparam int BYTE_W   = 2;
    localparam int FLD_W    = 5;

    // ********************************************
    // register offsets
    // ********************************************
    localparam logic [7:0] OFS_CMD   = 8'h00;
    localparam logic [7:0] OFS_RFSH  = 8'h04;
    localparam logic [7:0] OFS_CFG   = 8'h08;
    localparam logic [7:0] OFS_TPA   = 8'h0c;
    localparam logic [7:0] OFS_TPB   = 8'h10;
    localparam logic [7:0] OFS_TPC   = 8'h14;
    localparam logic [7:0] OFS_LPC   = 8'h1c;
    localparam logic [7:0] OFS_MDT   = 8'h20;
    localparam logic [7:0] OFS_DLL   = 8'h24;
    localparam logic [7:0] OFS_HSC   = 8'h2c;
    localparam logic [7:0] OFS_WGM   = 8'he4;
    localparam logic [7:0] OFS_WGS   = 8'he8;

    // ********************************************
    // reset values and writable masks
    // ********************************************
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] RST_CFG  = 32'h0000_7024;
    localparam logic [31:0] RST_TPA  = 32'h2022_7225;
    localparam logic [31:0] RST_TPB  = 32'h03c8_0808;
    localparam logic [31:0] RST_TPC  = 32'h0000_2062;
    localparam logic [31:0] RST_LPC  = 32'h0001_0000;
    localparam logic [31:0] RST_MDT  = 32'h0000_0010;
    localparam logic [31:0] RST_DLL  = 32'h0000_0001;
    localparam logic [31:0] MSK_CMD  = 32'h0000_0007;
    localparam logic [31:0] MSK_RFSH = 32'h0000_0fff;
    localparam logic [31:0] MSK_WGM  = 32'h0000_0001;

    // ********************************************
    // field positions
    // ********************************************
    localparam int CFG_NC_LSB = 0;
    localparam int CFG_NR_LSB = 2;
    localparam int CFG_NB_BIT = 20;
    localparam int CFG_DEC_BIT = 22;
    localparam int MDT_HALF_BIT = 4;
    localparam int WGM_EN_BIT = 0;
    localparam int WGS_VIOL_BIT = 0;
    localparam int WGS_SRC_LSB = 8;

    // ********************************************
    // address split widths
    // ********************************************
    localparam logic [4:0] COL_BASE_HALF = 5'h09;
    localparam logic [4:0] COL_BASE_FULL = 5'h08;
    localparam logic [4:0] ROW_BASE      = 5'h0b;
    localparam logic [4:0] BYTE_HALF     = 5'h01;
    localparam logic [4:0] BYTE_FULL     = 5'h02;
    localparam logic [4:0] BANK_FOUR     = 5'h02;
    localparam logic [4:0] BANK_EIGHT    = 5'h03;

    typedef enum logic [2:0] {
        SAC_CMD_NORMAL   = 3'b000,
        SAC_CMD_NOP      = 3'b001,
        SAC_CMD_PRECHG   = 3'b010,
        SAC_CMD_LOADMR   = 3'b011,
        SAC_CMD_AUTOREF  = 3'b100,
        SAC_CMD_EXTMR    = 3'b101,
        SAC_CMD_DEEPPD   = 3'b110
    } sac_cmd_t;

endpackage : sac_pkg

// ### verilog/sac_addr_split.sv
`timescale 1ns/1ps
`default_nettype none
module sac_addr_split
    import sac_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic [SYS_A_W-1:0] sys_addr,
    input  wire logic               half_bus,
    input  wire logic               interleave,
    input  wire logic               eight_bank,
    input  wire logic [1:0]         col_sel,
    input  wire logic [1:0]         row_sel,
    output logic      [ROW_W-1:0]   row_r,
    output logic      [COL_W-1:0]   col_r,
    output logic      [BANK_W-1:0]  bank_r,
    output logic      [BYTE_W-1:0]  byte_r
);

    logic [4:0] byte_w, col_w, row_w, bank_w;
    logic [4:0] row_lsb, bank_lsb;
    logic [SYS_A_W-1:0] col_f, row_f, bank_f, byte_f;

    function automatic logic [SYS_A_W-1:0] fld(
        input logic [SYS_A_W-1:0] a,
        input logic [4:0]         lsb,
        input logic [4:0]         w
    );
        fld = (a >> lsb) & ((28'h1 << w) - 28'h1);
    endfunction : fld

    always_comb begin
        byte_w = half_bus ? BYTE_HALF : BYTE_FULL;
        col_w  = (half_bus ? COL_BASE_HALF : COL_BASE_FULL)
               + {3'h0, col_sel};
        row_w  = ROW_BASE + {3'h0, row_sel};
        bank_w = (half_bus && eight_bank) ? BANK_EIGHT : BANK_FOUR;
        if (half_bus && interleave) begin
            // bank right above the column field
            bank_lsb = byte_w + col_w;
            row_lsb  = bank_lsb + bank_w;
        end else begin
            row_lsb  = byte_w + col_w;
            bank_lsb = row_lsb + row_w;
        end
        byte_f = fld(sys_addr, 5'h00, byte_w);
        col_f  = fld(sys_addr, byte_w, col_w);
        row_f  = fld(sys_addr, row_lsb, row_w);
        bank_f = fld(sys_addr, bank_lsb, bank_w);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            row_r  <= '0;
            col_r  <= '0;
            bank_r <= '0;
            byte_r <= '0;
        end else begin
            row_r  <= row_f[ROW_W-1:0];
            col_r  <= col_f[COL_W-1:0];
            bank_r <= bank_f[BANK_W-1:0];
            byte_r <= byte_f[BYTE_W-1:0];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    half_ilv_a: assert property (
        half_bus && interleave && eight_bank && col_sel == 2'h1
        |=> col_r == {2'h0, $past(sys_addr[10:1])}
            && bank_r == $past(sys_addr[13:11]))
        else $error("16-bit interleaved split wrong");
    full_2k_a: assert property (
        !half_bus && row_sel == 2'h0 && col_sel == 2'h0
        |=> row_r == {3'h0, $past(sys_addr[20:10])}
            && bank_r == {1'b0, $past(sys_addr[22:21])})
        else $error("32-bit 2K row split wrong");
    full_4k_a: assert property (
        !half_bus && row_sel == 2'h1 && col_sel == 2'h2
        |=> row_r == {2'h0, $past(sys_addr[23:12])})
        else $error("32-bit 4K row split wrong");
    full_8k_a: assert property (
        !half_bus && row_sel == 2'h2 && col_sel == 2'h3
        |=> bank_r[1:0] == $past(sys_addr[27:26]))
        else $error("32-bit 8K bank split wrong");
    byte_sel_a: assert property (
        !half_bus |=> byte_r == $past(sys_addr[1:0]))
        else $error("byte offset wrong");

endmodule : sac_addr_split
`default_nettype wire

// ### verilog/sac_refresh_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sac_refresh_timer
    import sac_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [RFSH_W-1:0] period,
    input  wire logic              reload,
    output logic                   pulse_r
);

    logic [RFSH_W-1:0] count_r;

    // a period of zero parks the timer, no refresh is asked for
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_r <= '0;
        end else if (reload || count_r <= 12'h001) begin
            count_r <= period;
        end else begin
            count_r <= count_r - 12'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= !reload && count_r == 12'h001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    rfsh_reload_a: assert property (
        pulse_r |-> count_r == $past(period))
        else $error("timer not reloaded at pulse");

endmodule : sac_refresh_timer
`default_nettype wire

// ### verilog/sac_regif.sv
`timescale 1ns/1ps
`default_nettype none
module sac_regif
    import sac_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic      [DATA_W-1:0]  prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [SYS_A_W-1:0] sys_addr,
    input  wire logic               mem_access,
    output logic      [ROW_W-1:0]   mem_row,
    output logic      [COL_W-1:0]   mem_col,
    output logic      [BANK_W-1:0]  mem_bank,
    output logic      [BYTE_W-1:0]  mem_byte_sel,
    output logic      [MODE_W-1:0]  cmd_mode,
    output logic                    cmd_issue,
    output logic      [MODE_W-1:0]  cmd_code,
    output logic                    deep_power_down,
    output logic                    refresh_req,
    output logic      [DATA_W-1:0]  timing_a,
    output logic      [DATA_W-1:0]  timing_b,
    output logic      [DATA_W-1:0]  timing_c,
    output logic      [DATA_W-1:0]  low_power,
    output logic      [DATA_W-1:0]  high_speed
);

    // ********************************************
    // bus decode
    // ********************************************
    logic              wr_en, rd_setup, guard_on;
    logic              wr_prot, viol;
    logic [DATA_W-1:0] rd_nxt, prdata_r;
    logic [DATA_W-1:0] cmd_r, rfsh_r, cfg_r;
    logic [DATA_W-1:0] tpa_r, tpb_r, tpc_r;
    logic [DATA_W-1:0] lpc_r, mdt_r, hsc_r;
    logic [DATA_W-1:0] wgm_r, wgs_r;
    logic              issue_r;
    logic [MODE_W-1:0] code_r;
    logic              rfsh_load;
    logic [RFSH_W-1:0] rfsh_period;
    sac_cmd_t          mode;

    // zero wait states, no error answer: reserved slots read zero
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign guard_on = wgm_r[WGM_EN_BIT];
    assign wr_prot  = paddr == OFS_CMD || paddr == OFS_RFSH
                   || paddr == OFS_CFG;
    assign viol     = wr_en && guard_on && wr_prot;
    assign mode     = sac_cmd_t'(cmd_r[MODE_W-1:0]);

    // ********************************************
    // guarded registers
    // ********************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_r  <= RST_ZERO;
            rfsh_r <= RST_ZERO;
            cfg_r  <= RST_CFG;
        end else if (wr_en && !guard_on) begin
            unique case (paddr)
                OFS_CMD:  cmd_r  <= pwdata & MSK_CMD;
                OFS_RFSH: rfsh_r <= pwdata & MSK_RFSH;
                OFS_CFG:  cfg_r  <= pwdata;
                default:  cmd_r  <= cmd_r;
            endcase
        end
    end

    // ********************************************
    // open registers
    // ********************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tpa_r <= RST_TPA;
            tpb_r <= RST_TPB;
            tpc_r <= RST_TPC;
            lpc_r <= RST_LPC;
            mdt_r <= RST_MDT;
            hsc_r <= RST_ZERO;
            wgm_r <= RST_ZERO;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_TPA: tpa_r <= pwdata;
                OFS_TPB: tpb_r <= pwdata;
                OFS_TPC: tpc_r <= pwdata;
                OFS_LPC: lpc_r <= pwdata;
                OFS_MDT: mdt_r <= pwdata;
                OFS_HSC: hsc_r <= pwdata;
                OFS_WGM: wgm_r <= pwdata & MSK_WGM;
                default: tpa_r <= tpa_r;
            endcase
        end
    end

    // ********************************************
    // guard status
    // ********************************************
    // a fresh violation wins over the clear-on-read of the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wgs_r <= RST_ZERO;
        end else if (viol) begin
            wgs_r <= RST_ZERO;
            wgs_r[WGS_VIOL_BIT] <= 1'b1;
            wgs_r[WGS_SRC_LSB +: PADDR_W] <= paddr;
        end else if (rd_setup && paddr == OFS_WGS) begin
            wgs_r <= RST_ZERO;
        end
    end

    // ********************************************
    // read path
    // ********************************************
    always_comb begin
        unique case (paddr)
            OFS_CMD:  rd_nxt = cmd_r;
            OFS_RFSH: rd_nxt = rfsh_r;
            OFS_CFG:  rd_nxt = cfg_r;
            OFS_TPA:  rd_nxt = tpa_r;
            OFS_TPB:  rd_nxt = tpb_r;
            OFS_TPC:  rd_nxt = tpc_r;
            OFS_LPC:  rd_nxt = lpc_r;
            OFS_MDT:  rd_nxt = mdt_r;
            OFS_DLL:  rd_nxt = RST_DLL;
            OFS_HSC:  rd_nxt = hsc_r;
            OFS_WGM:  rd_nxt = wgm_r;
            OFS_WGS:  rd_nxt = wgs_r;
            default:  rd_nxt = RST_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_r <= RST_ZERO;
        end else if (rd_setup) begin
            prdata_r <= rd_nxt;
        end
    end

    assign prdata = prdata_r;

    // ********************************************
    // command issue
    // ********************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            issue_r <= 1'b0;
            code_r  <= SAC_CMD_NORMAL;
        end else begin
            issue_r <= mem_access && mode >= SAC_CMD_NOP
                    && mode <= SAC_CMD_EXTMR;
            code_r  <= mem_access ? mode : code_r;
        end
    end

    assign cmd_mode        = cmd_r[MODE_W-1:0];
    assign cmd_issue       = issue_r;
    assign cmd_code        = code_r;
    assign deep_power_down = mode == SAC_CMD_DEEPPD;
    assign timing_a        = tpa_r;
    assign timing_b        = tpb_r;
    assign timing_c        = tpc_r;
    assign low_power       = lpc_r;
    assign high_speed      = hsc_r;

    // ********************************************
    // address split and refresh
    // ********************************************
    // the split follows the live config; reprogramming it mid-traffic
    // is left to software
    sac_addr_split u_split (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .sys_addr   (sys_addr),
        .half_bus   (mdt_r[MDT_HALF_BIT]),
        .interleave (cfg_r[CFG_DEC_BIT]),
        .eight_bank (cfg_r[CFG_NB_BIT]),
        .col_sel    (cfg_r[CFG_NC_LSB +: 2]),
        .row_sel    (cfg_r[CFG_NR_LSB +: 2]),
        .row_r      (mem_row),
        .col_r      (mem_col),
        .bank_r     (mem_bank),
        .byte_r     (mem_byte_sel)
    );

    // the timer reloads on the write edge, so it must see the new count
    assign rfsh_load   = wr_en && !guard_on && paddr == OFS_RFSH;
    assign rfsh_period = rfsh_load ? pwdata[RFSH_W-1:0]
                                   : rfsh_r[RFSH_W-1:0];

    sac_refresh_timer u_rfsh (
        .ref_clk (ref_clk),
        .rst     (rst),
        .period  (rfsh_period),
        .reload  (rfsh_load),
        .pulse_r (refresh_req)
    );

    // ********************************************
    // checks
    // ********************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    mode_write_a: assert property (
        wr_en && !guard_on && paddr == OFS_CMD
        |=> cmd_mode == $past(pwdata[2:0]) && cmd_r[31:3] == '0)
        else $error("mode write lost");
    guard_block_a: assert property (
        wr_en && guard_on && paddr == OFS_CMD |=> $stable(cmd_r))
        else $error("guarded mode write taken");
    guard_flag_a: assert property (
        viol |=> wgs_r[WGS_VIOL_BIT] ##1 wgs_r[WGS_VIOL_BIT]
                 || $past(rd_setup && paddr == OFS_WGS))
        else $error("guard violation not flagged");
    reset_vals_a: assert property (
        @(posedge ref_clk) $fell(rst) |-> cfg_r == RST_CFG
        && tpa_r == RST_TPA && tpb_r == RST_TPB && lpc_r == RST_LPC
        && mdt_r == RST_MDT && cmd_r == RST_ZERO)
        else $error("reset value wrong");
    dll_read_a: assert property (
        rd_setup && paddr == OFS_DLL |=> prdata == RST_DLL)
        else $error("delay loop info not one");
    resv_zero_a: assert property (
        rd_setup && (paddr == 8'h18 || paddr == 8'h28 || paddr == 8'hf0)
        |=> prdata == RST_ZERO)
        else $error("reserved read not zero");
    cmd_issue_a: assert property (
        mem_access && mode inside {[SAC_CMD_NOP:SAC_CMD_EXTMR]}
        |=> cmd_issue && cmd_code == $past(cmd_r[2:0]))
        else $error("command not issued");
    no_issue_a: assert property (
        !mem_access || mode == SAC_CMD_NORMAL || mode == SAC_CMD_DEEPPD
        |=> !cmd_issue)
        else $error("stray command issued");
    rfsh_mask_a: assert property (
        wr_en && !guard_on && paddr == OFS_RFSH
        |=> rfsh_r == ($past(pwdata) & MSK_RFSH))
        else $error("refresh count wrong");

    // ********************************************
    // checks: register writes and read data hold
    // ********************************************
    tpa_write_a: assert property (
        wr_en && paddr == OFS_TPA |=> tpa_r == $past(pwdata))
        else $error("timing a write lost");
    lpc_write_a: assert property (
        wr_en && paddr == OFS_LPC |=> lpc_r == $past(pwdata))
        else $error("low power write lost");
    hsc_write_a: assert property (
        wr_en && paddr == OFS_HSC |=> hsc_r == $past(pwdata))
        else $error("high speed write lost");
    wgm_write_a: assert property (
        wr_en && paddr == OFS_WGM
        |=> wgm_r == ($past(pwdata) & MSK_WGM))
        else $error("guard mode write lost");
    resv_write_a: assert property (
        wr_en && paddr == 8'h28 |=> $stable(hsc_r) && $stable(tpa_r))
        else $error("reserved write landed");

    rdata_hold_a: assert property (
        !rd_setup |=> $stable(prdata))
        else $error("read data moved");

    // ********************************************
    // checks: guard, commands, refresh
    // ********************************************
    guard_src_a: assert property (
        viol |=> wgs_r[WGS_SRC_LSB +: PADDR_W] == $past(paddr))
        else $error("guard source wrong");
    status_ro_a: assert property (
        wr_en && paddr == OFS_WGS |=> $stable(wgs_r))
        else $error("guard status written");
    status_clr_a: assert property (
        rd_setup && paddr == OFS_WGS |=> wgs_r == RST_ZERO)
        else $error("guard status not cleared");
    rfsh_guard_a: assert property (
        wr_en && guard_on && paddr == OFS_RFSH |=> $stable(rfsh_r))
        else $error("guarded refresh write taken");
    cfg_guard_a: assert property (
        wr_en && guard_on && paddr == OFS_CFG |=> $stable(cfg_r))
        else $error("guarded config write taken");

    issue_src_a: assert property (
        cmd_issue |-> $past(mem_access))
        else $error("issue without access");
    code_hold_a: assert property (
        !mem_access |=> $stable(cmd_code))
        else $error("command code moved");
    rfsh_idle_a: assert property (
        rfsh_r[RFSH_W-1:0] == '0 && $past(rfsh_r[RFSH_W-1:0]) == '0
        |-> !refresh_req)
        else $error("refresh with zero count");

    mode_wr_c: cover property (wr_en && paddr == OFS_CMD);
    viol_c:    cover property (viol ##1 wgs_r[WGS_VIOL_BIT]);
    issue_c:   cover property (cmd_issue);
    rfsh_c:    cover property (refresh_req);
    dpd_c:     cover property (deep_power_down);

endmodule : sac_regif
`default_nettype wire

// ### dv/sac_sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
// ******************************************************
// memory side: logs issued commands and refresh pulses
// ******************************************************
module sac_sdram_model
    import sac_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              cmd_issue,
    input  wire logic [MODE_W-1:0] cmd_code,
    input  wire logic              refresh_req,
    output logic      [MODE_W-1:0] last_cmd_r,
    output logic      [15:0]       n_ref_r
);
    // the memory takes a command only on the issue pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_cmd_r <= 3'h0;
        end else if (cmd_issue) begin
            last_cmd_r <= cmd_code;
        end
    end

    // each pulse starts one refresh sequence
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            n_ref_r <= 16'h0000;
        end else if (refresh_req) begin
            n_ref_r <= n_ref_r + 16'h0001;
        end
    end
endmodule : sac_sdram_model
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sac_pkg::*;
;
    logic                ref_clk;
    logic                rst;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [PADDR_W-1:0]  paddr;
    logic [DATA_W-1:0]   pwdata;
    logic [DATA_W-1:0]   prdata;
    logic [DATA_W-1:0]   rd;
    logic [DATA_W-1:0]   timing_a, timing_b, timing_c, low_power, high_speed;
    logic                pready;
    logic                pslverr;
    logic [SYS_A_W-1:0]  sys_addr;
    logic                mem_access;
    logic [ROW_W-1:0]    mem_row;
    logic [COL_W-1:0]    mem_col;
    logic [BANK_W-1:0]   mem_bank;
    logic [BYTE_W-1:0]   mem_byte_sel;
    logic [MODE_W-1:0]   cmd_mode;
    logic [MODE_W-1:0]   cmd_code;
    logic [MODE_W-1:0]   last_cmd;
    logic                cmd_issue;
    logic                deep_power_down;
    logic                refresh_req;
    logic [15:0]         n_ref;
    logic [15:0]         n0;
    int                  fails = 0;
    int                  n_tests = 0;
    int                  cycles = 0;
    int                  k;
    logic [7:0]  ofs [16] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h1c, 8'h20, 8'h24, 8'h2c, 8'he4, 8'he8, 8'h18, 8'h28, 8'h54, 8'hec};
    logic [31:0] rv  [16] = '{32'h0, 32'h0, 32'h7024, 32'h2022_7225,
        32'h03c8_0808, 32'h2062, 32'h1_0000, 32'h10, 32'h1, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] wv  [16] = '{32'h7, 32'hfff, 32'h0, 32'hffff_ffff,
        32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0, 32'h1,
        32'hffff_ffff, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

    sac_regif i_sac_regif (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_addr(sys_addr), .mem_access(mem_access), .mem_row(mem_row),
        .mem_col(mem_col), .mem_bank(mem_bank), .mem_byte_sel(mem_byte_sel),
        .cmd_mode(cmd_mode), .cmd_issue(cmd_issue), .cmd_code(cmd_code),
        .deep_power_down(deep_power_down), .refresh_req(refresh_req),
        .timing_a(timing_a), .timing_b(timing_b), .timing_c(timing_c),
        .low_power(low_power), .high_speed(high_speed));

    sac_sdram_model i_sac_sdram_model (.ref_clk(ref_clk), .rst(rst),
        .cmd_issue(cmd_issue), .cmd_code(cmd_code),
        .refresh_req(refresh_req), .last_cmd_r(last_cmd), .n_ref_r(n_ref));

    // ******************************************************
    // shared tasks
    // ******************************************************
    task automatic close_out();
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // an idle cycle closes each transfer so no strobe flips twice at once
    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        psel = 1'b1;
        pwrite = 1'b1;
        paddr = a;
        pwdata = d;
        @(posedge ref_clk);
        #1 penable = 1'b1;
        @(posedge ref_clk);
        #1 psel = 1'b0;
        penable = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : apb_wr

    task automatic apb_rd(input logic [7:0] a, output logic [31:0] d);
        psel = 1'b1;
        pwrite = 1'b0;
        paddr = a;
        @(posedge ref_clk);
        #1 penable = 1'b1;
        @(posedge ref_clk);
        d = prdata;
        check(32'({pready, pslverr}), 32'h2);
        #1 psel = 1'b0;
        penable = 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : apb_rd

    function automatic logic [31:0] fld(input int lsb, input int w);
        return (32'(sys_addr) >> lsb) & ((32'h1 << w) - 32'h1);
    endfunction : fld

    // ilv puts the bank field below the row field
    task automatic split_chk(input int bw, input int cw, input int rw,
                             input int kw, input bit ilv);
        sys_addr = 28'hb5a_3c69;
        @(posedge ref_clk);
        #1;
        check(32'(mem_byte_sel), fld(0, bw));
        check(32'(mem_col), fld(bw, cw));
        check(32'(mem_row), fld(bw + cw + (ilv ? kw : 0), rw));
        check(32'(mem_bank), fld(bw + cw + (ilv ? 0 : rw), kw));
    endtask : split_chk

    task automatic wait_ref(output int n);
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (refresh_req !== 1'b1 && n < 60);
    endtask : wait_ref

    // ******************************************************
    // clock, reset, watchdog
    // ******************************************************
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            close_out();
        end
    end

    // ******************************************************
    // test sequence
    // ******************************************************
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sys_addr = 28'h0;
        mem_access = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            apb_rd(ofs[i], rd);
            check(rd, rv[i]);
        end
        // configuration and device type stay put for the split tests
        for (int i = 0; i < 16; i++) begin
            if (ofs[i] != 8'h08 && ofs[i] != 8'h20) begin
                apb_wr(ofs[i], 32'hffff_ffff);
                apb_rd(ofs[i], rd);
                check(rd, wv[i]);
            end
        end
        check(timing_a, 32'hffff_ffff);
        check(timing_b, 32'hffff_ffff);
        check(timing_c, 32'hffff_ffff);
        check(low_power, 32'hffff_ffff);
        check(high_speed, 32'hffff_ffff);
        apb_wr(8'h04, 32'h10);
        apb_rd(8'h04, rd);
        check(rd, 32'hfff);
        apb_rd(8'he8, rd);
        check(rd, 32'h0401);
        apb_rd(8'he8, rd);
        check(rd, 32'h0);
        apb_wr(8'h00, 32'h3);
        apb_rd(8'h00, rd);
        check(rd, 32'h7);
        apb_wr(8'h08, 32'h0);
        apb_rd(8'h08, rd);
        check(rd, 32'h7024);
        apb_wr(8'he4, 32'h0);
        for (int m = 0; m < 8; m++) begin
            apb_wr(8'h00, 32'(m));
            mem_access = 1'b1;
            @(posedge ref_clk);
            #1 mem_access = 1'b0;
            check(32'(cmd_issue), 32'(m > 0 && m < 6));
            check(32'(deep_power_down), 32'(m == 6));
            check(32'(cmd_mode), 32'(m));
        end
        check(32'(last_cmd), 32'h5);
        apb_wr(8'h00, 32'h0);
        // widths are programmed before any access is split
        apb_wr(8'h20, 32'h10);
        apb_wr(8'h08, 32'h0050_000d);
        split_chk(1, 10, 14, 3, 1'b1);
        apb_wr(8'h08, 32'h0010_0009);
        split_chk(1, 10, 13, 3, 1'b0);
        apb_wr(8'h20, 32'h0);
        for (int nr = 0; nr < 3; nr++) begin
            for (int nc = 0; nc < 4; nc++) begin
                apb_wr(8'h08, 32'(nr * 4 + nc));
                split_chk(2, 8 + nc, 11 + nr, 2, 1'b0);
            end
        end
        apb_wr(8'h04, 32'd20);
        wait_ref(k);
        wait_ref(k);
        check(32'(k), 32'd20);
        apb_wr(8'h04, 32'h0);
        n0 = n_ref;
        repeat (60) @(posedge ref_clk);
        #1;
        check(32'(n_ref), 32'(n0));
        close_out();
    end
endmodule : tb_top
`default_nettype wire
